/* sbd_pkg.sv */
// Shared constants for the serial data buffer and bit-rate generator
package sbd_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 8;
  localparam logic [7:0]  STATUS_ADDR   = 8'h16;
  localparam logic [7:0]  DATA_ADDR     = 8'h18;
  localparam logic [7:0]  RATE_ADDR     = 8'h19;
  // Field layout of bit_rate_select
  localparam int          PRE_LSB       = 4;
  localparam int          PRE_W         = 2;
  localparam int          RATE_LSB      = 0;
  localparam int          RATE_W        = 3;
  localparam logic [1:0]  PRE_RESET     = 2'h0;
  localparam logic [2:0]  RATE_RESET    = 3'h0;
  localparam logic        TE_RESET      = 1'b1;
  localparam logic        RF_RESET      = 1'b0;
  localparam logic [7:0]  RD_RESET      = 8'h00;
  // Flag positions in primary_status_register
  localparam int          TE_BIT        = 7;
  localparam int          RF_BIT        = 5;
  // Prescale codes and divisors
  localparam logic [1:0]  PRE_CODE_1    = 2'h0;
  localparam logic [1:0]  PRE_CODE_3    = 2'h1;
  localparam logic [1:0]  PRE_CODE_4    = 2'h2;
  localparam logic [5:0]  PRE_DIV_1     = 6'h01;
  localparam logic [5:0]  PRE_DIV_3     = 6'h03;
  localparam logic [5:0]  PRE_DIV_4     = 6'h04;
  localparam logic [5:0]  PRE_DIV_13    = 6'h0d;
  // Fixed divide of 64 split as 4 before the tick and 16 per bit
  localparam int          FIXED_DIV     = 64;
  localparam int          OVERSAMPLE    = 16;
  localparam logic [5:0]  FIXED_PRE     = 6'(FIXED_DIV / OVERSAMPLE);
  localparam logic [6:0]  RATE_ONE      = 7'h01;
  localparam logic [5:0]  PRE_ONE       = 6'h01;
endpackage

/* sbd_rate_if.sv */
// Selection and tick carrier between register logic and divider chain
`timescale 1ns/10ps
interface sbd_rate_if;
  logic [1:0] prescale_sel;
  logic [2:0] rate_div_sel;
  logic       tick16;
  modport ctl (output prescale_sel, output rate_div_sel, input tick16);
  modport gen (input prescale_sel, input rate_div_sel, output tick16);
endinterface

/* sbd_divider.sv */
// Free-running divider chain producing the 16x bit-rate tick
`timescale 1ns/10ps
module sbd_divider (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  sbd_rate_if.gen   rate
);
  function automatic logic [5:0] prescale_divisor(input logic [1:0] code);
    case (code)
      sbd_pkg::PRE_CODE_1: prescale_divisor = sbd_pkg::PRE_DIV_1;
      sbd_pkg::PRE_CODE_3: prescale_divisor = sbd_pkg::PRE_DIV_3;
      sbd_pkg::PRE_CODE_4: prescale_divisor = sbd_pkg::PRE_DIV_4;
      default:             prescale_divisor = sbd_pkg::PRE_DIV_13;
    endcase
  endfunction

  logic [5:0] pre_cnt;
  logic [6:0] rate_cnt;
  logic       tick;
  wire  [5:0] pre_last  = 6'(sbd_pkg::FIXED_PRE * prescale_divisor(rate.prescale_sel))
                          - sbd_pkg::PRE_ONE;
  wire  [6:0] rate_last = 7'((8'h01 << rate.rate_div_sel) - 8'h01);
  // Compare with >= so a smaller divisor written mid-count cannot strand the counter
  wire        pre_wrap  = (pre_cnt >= pre_last);
  wire        rate_wrap = (rate_cnt >= rate_last);

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pre_cnt  <= '0;
      rate_cnt <= '0;
      tick     <= 1'b0;
    end
    else
    begin
      pre_cnt  <= pre_wrap ? '0 : pre_cnt + sbd_pkg::PRE_ONE;
      if (pre_wrap)
        rate_cnt <= rate_wrap ? '0 : rate_cnt + sbd_pkg::RATE_ONE;
      tick     <= pre_wrap && rate_wrap;
    end
  end

  assign rate.tick16 = tick;
endmodule

/* sbd_data_buffer.sv */
// Serial data buffer, bit-rate select register and flag clearing sequences
// How it works
// - Data buffer keeps contents through system reset.
// - Buffer sits between bus and shift registers.
// - Reading data location returns received byte.
// - Writing data location loads transmit byte only.
// - One bit rate serves receiver and transmitter.
// - Prescale codes select 1, 3, 4, 13.
// - Prescale field resets to zero, read/write.
// - Rate field selects power of two, resets zero.
// - Bit rate is clock over 64*PD*BD.
// - Status read then data read clears receive-full.
// - Status read then data write clears transmit-empty.
`timescale 1ns/10ps
module sbd_data_buffer (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       rd_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] rx_data_in,
  input  wire logic       rx_load_in,
  input  wire logic       tx_take_in,
  output logic      [7:0] rd_data_out,
  output logic      [7:0] tx_data_out,
  output logic            tx_pending_out,
  output logic            receive_full_flag_out,
  output logic            transmit_empty_flag_out,
  output logic            bit_tick16_out
);
  sbd_rate_if rate ();

  logic [7:0] rx_buf;
  logic [7:0] tx_buf;
  logic [1:0] prescale_sel;
  logic [2:0] rate_div_sel;
  logic       rf;
  logic       te;
  logic       rf_armed;
  logic       te_armed;
  logic       tx_pend;
  logic [7:0] rd_q;
  logic       tick_q;

  wire        hit_status = (addr_in == sbd_pkg::STATUS_ADDR);
  wire        hit_data   = (addr_in == sbd_pkg::DATA_ADDR);
  wire        hit_rate   = (addr_in == sbd_pkg::RATE_ADDR);
  wire        rd_status  = rd_in && hit_status;
  wire        rd_data    = rd_in && hit_data;
  wire        wr_data    = wr_in && hit_data;
  wire        wr_rate    = wr_in && hit_rate;
  wire        clr_rf     = rd_data && rf_armed;
  wire        clr_te     = wr_data && te_armed;
  wire [7:0]  status_val = 8'((rf ? (8'h01 << sbd_pkg::RF_BIT) : 8'h00)
                            | (te ? (8'h01 << sbd_pkg::TE_BIT) : 8'h00));
  wire [7:0]  rate_val   = 8'((8'(prescale_sel) << sbd_pkg::PRE_LSB)
                            | (8'(rate_div_sel) << sbd_pkg::RATE_LSB));
  // Unmapped addresses read as zero
  wire [7:0]  next_rd    = hit_data   ? rx_buf     :
                           hit_status ? status_val :
                           hit_rate   ? rate_val   : 8'h00;

  assign rate.prescale_sel = prescale_sel;
  assign rate.rate_div_sel = rate_div_sel;

  // One divider drives both directions through the single tick
  sbd_divider u_div (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .rate     (rate.gen)
  );

  // Buffers carry no reset so system reset leaves them untouched
  always_ff @(posedge clk_in)
  begin
    if (rx_load_in)
      rx_buf <= rx_data_in;
    if (wr_data)
      tx_buf <= wr_data_in;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      prescale_sel <= sbd_pkg::PRE_RESET;
      rate_div_sel <= sbd_pkg::RATE_RESET;
    end
    else if (wr_rate)
    begin
      prescale_sel <= wr_data_in[sbd_pkg::PRE_LSB +: sbd_pkg::PRE_W];
      rate_div_sel <= wr_data_in[sbd_pkg::RATE_LSB +: sbd_pkg::RATE_W];
    end
  end

  // Receive-full: a new load in the clearing cycle wins over the clear
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rf       <= sbd_pkg::RF_RESET;
      rf_armed <= 1'b0;
    end
    else
    begin
      rf       <= rx_load_in | (rf & ~clr_rf);
      rf_armed <= (rd_status & rf) | (rf_armed & ~rd_data & ~rx_load_in);
    end
  end

  // Transmit-empty: hand-off to the shift register wins over the clear
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      te       <= sbd_pkg::TE_RESET;
      te_armed <= 1'b0;
      tx_pend  <= 1'b0;
    end
    else
    begin
      te       <= tx_take_in | (te & ~clr_te);
      te_armed <= (rd_status & te) | (te_armed & ~wr_data & ~tx_take_in);
      tx_pend  <= clr_te | (tx_pend & ~tx_take_in);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_q   <= sbd_pkg::RD_RESET;
      tick_q <= 1'b0;
    end
    else
    begin
      if (rd_in)
        rd_q <= next_rd;
      tick_q <= rate.tick16;
    end
  end

  assign rd_data_out             = rd_q;
  assign tx_data_out             = tx_buf;
  assign tx_pending_out          = tx_pend;
  assign receive_full_flag_out   = rf;
  assign transmit_empty_flag_out = te;
  assign bit_tick16_out          = tick_q;
endmodule

/* sbd_checker.sv */
// Concurrent checks on the serial data buffer ports
`timescale 1ns/10ps
module sbd_checker (
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic       rd_in,
  input wire logic       wr_in,
  input wire logic       rx_load_in,
  input wire logic       tx_take_in,
  input wire logic [7:0] rd_data_out,
  input wire logic [7:0] tx_data_out,
  input wire logic       tx_pending_out,
  input wire logic       receive_full_flag_out,
  input wire logic       transmit_empty_flag_out,
  input wire logic       bit_tick16_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  wire rf  = receive_full_flag_out;
  wire te  = transmit_empty_flag_out;
  wire dat = addr_in == sbd_pkg::DATA_ADDR;
  wire sta = addr_in == sbd_pkg::STATUS_ADDR;
  wire map = dat || sta || addr_in == sbd_pkg::RATE_ADDR;
  AST_STATUS: assert property (rd_in && sta |=> rd_data_out ==
    {$past(te), 1'b0, $past(rf), 5'h00}) else $error("status read wrong");
  AST_UNMAP: assert property (rd_in && !map |=> rd_data_out == 8'h00)
    else $error("unmapped read not zero");
  AST_RF_SET: assert property (rx_load_in |=> rf)
    else $error("receive full not set");
  AST_TE_SET: assert property (tx_take_in |=> te)
    else $error("transmit empty not set");
  AST_RF_KEEP: assert property (rf && !(rd_in && dat) |=> rf)
    else $error("receive full lost");
  AST_TE_KEEP: assert property (te && !(wr_in && dat) |=> te)
    else $error("transmit empty lost");
  AST_TX_LOAD: assert property (wr_in && dat |=> tx_data_out == $past(wr_data_in))
    else $error("transmit byte not loaded");
  AST_TICK: assert property (bit_tick16_out |=> !bit_tick16_out [*3])
    else $error("tick too close");
  AST_PEND_SET: assert property ($fell(te) |-> tx_pending_out)
    else $error("pending not set");
  AST_PEND_CLR: assert property (tx_take_in && !(wr_in && dat) |=> !tx_pending_out)
    else $error("pending not cleared");
endmodule
bind sbd_data_buffer sbd_checker i_sbd_checker (.*);

/* sbd_line_model.sv */
// Remote transceiver: hands in received bytes, drains the transmit byte
`timescale 1ns/10ps
module sbd_line_model (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       send_in,
  input  wire logic [7:0] byte_in,
  input  wire logic [3:0] delay_in,
  input  wire logic       tx_pending_in,
  input  wire logic [7:0] tx_data_in,
  output logic      [7:0] rx_data_out,
  output logic            rx_load_out,
  output logic            tx_take_out,
  output logic      [7:0] taken_out
);
  logic [3:0] wait_q;
  always @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      {rx_load_out, tx_take_out, wait_q} <= 6'h00;
      rx_data_out <= 8'h5a;
    end
    else
    begin
      rx_load_out <= send_in;
      // Stale data is scrambled so nothing passes by luck
      rx_data_out <= send_in ? byte_in : ~rx_data_out;
      if (tx_pending_in && !tx_take_out && wait_q >= delay_in)
      begin
        tx_take_out <= 1'b1;
        taken_out   <= tx_data_in;
        wait_q      <= 4'h0;
      end
      else
      begin
        tx_take_out <= 1'b0;
        wait_q      <= (tx_pending_in && !tx_take_out) ? wait_q + 4'h1 : 4'h0;
      end
    end
endmodule

/* test_sci_baud_and_data_buffer.sv */
// Random and corner tests of the data buffer and bit-rate generator
`timescale 1ns/10ps
module test_sci_baud_and_data_buffer;
  logic       clk_in = 0, rst_n_in = 0, rd_in = 0, wr_in = 0, send = 0, rx_load_in, tx_take_in;
  logic       tx_pending_out, receive_full_flag_out, transmit_empty_flag_out, bit_tick16_out;
  logic [7:0] addr_in = 0, wr_data_in = 0, rx_data_in, rd_data_out, tx_data_out, taken, b, q;
  logic [3:0] dly = 0;
  int         err_total = 0, checked = 0, c;
  always #5 clk_in = ~clk_in;
  sbd_data_buffer i_sbd_data_buffer (.*);
  sbd_line_model i_sbd_line_model (.clk_in(clk_in), .rst_n_in(rst_n_in), .send_in(send),
    .byte_in(b), .delay_in(dly), .tx_pending_in(tx_pending_out), .tx_data_in(tx_data_out),
    .rx_data_out(rx_data_in), .rx_load_out(rx_load_in), .tx_take_out(tx_take_in),
    .taken_out(taken));
  task automatic results;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge clk_in);
    rd_in <= !w;
    wr_in <= w;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clk_in);
    rd_in <= 0;
    wr_in <= 0;
    #1;
  endtask
  task automatic wt;
    c = 0;
    do
    begin
      @(posedge clk_in);
      #1 c++;
    end while (bit_tick16_out !== 1 && c < 3000);
    if (c >= 3000)
    begin
      err_total++;
      results;
    end
  endtask
  // Tick period in clocks is 64*PD*BD divided by the 16 ticks of a bit
  function automatic logic [15:0] per(logic [7:0] v);
    return 16'(4 * (v[5:4] == 0 ? 1 : v[5:4] == 1 ? 3 : v[5:4] == 2 ? 4 : 13) << v[2:0]);
  endfunction
  initial
  begin
    void'($urandom(20));
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1;
    acc(0, 8'h19, 0);
    chk("rate reset", 0, rd_data_out);
    acc(0, 8'h16, 0);
    chk("status reset", 8'h80, rd_data_out);
    acc(0, 8'h21, 0);
    chk("unmapped", 0, rd_data_out);
    $display("reset value test done");
    for (int p = 0; p < 5; p++)
    begin
      q = {2'h0, 2'(p), 1'b0, p == 4 ? 3'h7 : 3'($urandom_range(2))};
      acc(1, 8'h19, q);
      acc(0, 8'h19, 0);
      chk("rate reg", q, rd_data_out);
      wt;
      wt;
      chk("tick period", per(q), 16'(c));
      $display("rate test %0d done", p);
    end
    repeat (3)
    begin
      @(posedge clk_in);
      b <= 8'($urandom);
      dly <= 4'($urandom_range(6));
      send <= 1;
      @(posedge clk_in);
      send <= 0;
      acc(0, 8'h18, 0);
      chk("rx early", b, rd_data_out);
      chk("rf kept", 1, receive_full_flag_out);
      acc(1, 8'h16, 0);
      acc(0, 8'h16, 0);
      chk("status", 8'ha0, rd_data_out);
      acc(0, 8'h18, 0);
      chk("rf clear", 0, receive_full_flag_out);
      q = 8'($urandom);
      acc(1, 8'h18, q);
      chk("te clear", 0, transmit_empty_flag_out);
      chk("pending", 1, tx_pending_out);
      repeat (12) @(posedge clk_in);
      #1 chk("taken", q, taken);
      chk("pending clear", 0, tx_pending_out);
      chk("te set", 1, transmit_empty_flag_out);
      acc(0, 8'h18, 0);
      chk("rx kept", b, rd_data_out);
      $display("byte test done");
    end
    @(posedge clk_in);
    rst_n_in <= 0;
    @(posedge clk_in);
    rst_n_in <= 1;
    acc(0, 8'h18, 0);
    chk("rx after reset", b, rd_data_out);
    $display("mid-run reset test done");
    results;
  end
endmodule
